// File: shared/ssx_regs.svh
// Function
// - Arithmetic shift right keeps bit 7, copies to 6
// - Shift flags: carry=old bit0, Z, S, V cleared
// - Shift opcodes D0 direct, D1 indirect, 4 cycles
// - Stop halts CPU and system clocks
// - Stop retains all register contents
// - Stop leaves only on reset or interrupt
// - Stop opcode 7F, one byte, flags unaffected
// - Stop needs unlock A5, else jump reset
// - Subtract stores dst minus src, src kept
// - Subtract flags: borrow, zero, sign, overflow
// - Subtract opcodes 22 to 26, lengths, cycles
// - Inverted mask test: (not dst) and src
// - Inverted mask test: C kept, Z, S, V cleared
// - Inverted mask test opcodes 62 to 66
// - Mask test ANDs dst and src, sets Z
// - Mask test: C kept, S bit7, V cleared
// - Mask test opcodes 72 to 76
`ifndef SSX_REGS_SVH
`define SSX_REGS_SVH
`define SSX_OP_SHIFT_R 8'hd0
`define SSX_OP_SHIFT_IR 8'hd1
`define SSX_OP_STOP 8'h7f
`define SSX_GRP_SUB 4'h2
`define SSX_GRP_INVTEST 4'h6
`define SSX_GRP_TEST 4'h7
`define SSX_LO_RR 4'h2
`define SSX_LO_RIR 4'h3
`define SSX_LO_GRG 4'h4
`define SSX_LO_GIR 4'h5
`define SSX_LO_GIM 4'h6
`define SSX_UNLOCK_KEY 8'ha5
`define SSX_RESET_PC 16'h0100
`define SSX_WREG_BASE 8'hc0
`define SSX_CYC_SHORT 3'h4
`define SSX_CYC_LONG 3'h6
`define SSX_CYC_LAST 3'h2
`define SSX_LEN_TWO 2'h2
`define SSX_LEN_THREE 2'h3
`define SSX_LEN_ONE 2'h1
`endif

// File: shared/ssx_pkg.sv
package ssx_pkg;
   // Flags as the core holds them
   typedef struct packed {
      logic c;
      logic z;
      logic s;
      logic v;
   } ssx_flags_t;
   // Register file write request
   typedef struct packed {
      logic en;
      logic [7:0] addr;
      logic [7:0] data;
   } ssx_wr_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PTR = 3'b001,
      ST_OPS = 3'b010,
      ST_EXEC = 3'b011,
      ST_WAIT = 3'b100,
      ST_STOP = 3'b101
   } ssx_state_t;
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_SHIFT = 3'b001,
      OP_SUB = 3'b010,
      OP_INVTEST = 3'b011,
      OP_TEST = 3'b100,
      OP_STOP = 3'b101
   } ssx_op_t;
endpackage : ssx_pkg

// File: logic/ssx_exec.sv
`timescale 1ns/10ps
`include "ssx_regs.svh"
// Executes the instruction group. Operands come from a register file with a
// combinational read port; the register file lives outside and keeps its
// contents while clocks are gated.
module ssx_exec #(
   parameter int DATA_W = 8
) (
   input wire logic clk_i, // 125 MHz core clock
   input wire logic reset_n_i, // Async active-low reset
   input wire logic start_i, // Pulse: instruction bytes valid
   input wire logic [7:0] opcode_i, // First instruction byte
   input wire logic [7:0] byte1_i, // Second byte
   input wire logic [7:0] byte2_i, // Third byte
   input wire logic [3:0] wbank_i, // Working register bank select
   input wire logic [7:0] unlock_i, // Stop unlock register contents
   input wire logic ext_irq_i, // External interrupt wake
   input wire ssx_pkg::ssx_flags_t flags_i, // Current flags
   output logic [7:0] rd_addr_o, // Register file read address
   input wire logic [7:0] rd_data_i, // Register file read data
   output ssx_pkg::ssx_wr_t wr_o, // Register file write
   output ssx_pkg::ssx_flags_t flags_o, // New flags
   output logic flags_we_o, // Pulse: load flags
   output logic pc_reset_o, // Pulse: load PC with reset address
   output logic [15:0] pc_value_o, // PC value to load
   output logic clk_halt_o, // Level: CPU and system clocks stopped
   output logic done_o, // Pulse: instruction retired
   output logic [1:0] length_o, // Byte length of retired instruction
   output logic busy_o // Level: instruction in progress
);
   // Refuse widths the byte-wide datapath cannot serve
   if (DATA_W != 8) begin : g_width_check
      $error("ssx_exec serves 8-bit data only");
   end

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   // Expand a 4-bit working register into a register file address
   function automatic logic [7:0] wreg(input logic [3:0] bank, input logic [3:0] r);
      wreg = `SSX_WREG_BASE | {3'h0, bank[0], r};
   endfunction : wreg

   ssx_pkg::ssx_state_t state, next_state;
   ssx_pkg::ssx_op_t op, next_op;
   logic busy, next_busy;
   logic [15:0] pc_val, next_pc_val;
   logic [7:0] dst_addr, next_dst_addr;
   logic [7:0] src_addr, next_src_addr;
   logic [7:0] dst_val, next_dst_val;
   logic [7:0] src_val, next_src_val;
   logic src_ind, next_src_ind;
   logic dst_ind, next_dst_ind;
   logic imm, next_imm;
   logic [2:0] cyc, next_cyc;
   logic [1:0] len, next_len;
   logic [7:0] rd_addr, next_rd_addr;
   ssx_pkg::ssx_wr_t wr, next_wr;
   ssx_pkg::ssx_flags_t flg, next_flg;
   logic flg_we, next_flg_we;
   logic pc_rst, next_pc_rst;
   logic halt, next_halt;
   logic done, next_done;
   logic [1:0] len_o, next_len_o;

   // ----------------------------------------
   // Next-state and datapath
   // ----------------------------------------
   // One process carries the sequencing; operands are read one per cycle
   always_comb begin
      logic [8:0] diff;
      logic [7:0] res;
      diff = 9'h000;
      res = 8'h00;
      next_state = state;
      next_op = op;
      next_pc_val = `SSX_RESET_PC;
      next_dst_addr = dst_addr;
      next_src_addr = src_addr;
      next_dst_val = dst_val;
      next_src_val = src_val;
      next_src_ind = src_ind;
      next_dst_ind = dst_ind;
      next_imm = imm;
      next_cyc = cyc;
      next_len = len;
      next_rd_addr = rd_addr;
      next_wr = '0;
      next_flg = flg;
      next_flg_we = 1'b0;
      next_pc_rst = 1'b0;
      next_halt = halt;
      next_done = 1'b0;
      next_len_o = len_o;
      case (state)
         ssx_pkg::ST_IDLE: begin
            if (start_i) begin
               next_src_ind = 1'b0;
               next_dst_ind = 1'b0;
               next_imm = 1'b0;
               next_op = ssx_pkg::OP_NONE;
               if (opcode_i == `SSX_OP_SHIFT_R || opcode_i == `SSX_OP_SHIFT_IR) begin
                  next_op = ssx_pkg::OP_SHIFT;
                  next_dst_addr = byte1_i;
                  next_dst_ind = (opcode_i == `SSX_OP_SHIFT_IR);
                  next_len = `SSX_LEN_TWO;
                  next_cyc = `SSX_CYC_SHORT;
               end else if (opcode_i == `SSX_OP_STOP) begin
                  next_op = ssx_pkg::OP_STOP;
                  next_len = `SSX_LEN_ONE;
                  next_cyc = `SSX_CYC_SHORT;
               end else if ((opcode_i[7:4] == `SSX_GRP_SUB ||
                             opcode_i[7:4] == `SSX_GRP_INVTEST ||
                             opcode_i[7:4] == `SSX_GRP_TEST) &&
                            opcode_i[3:0] >= `SSX_LO_RR && opcode_i[3:0] <= `SSX_LO_GIM) begin
                  // Shared table for all three groups
                  if (opcode_i[7:4] == `SSX_GRP_SUB) next_op = ssx_pkg::OP_SUB;
                  else if (opcode_i[7:4] == `SSX_GRP_INVTEST) next_op = ssx_pkg::OP_INVTEST;
                  else next_op = ssx_pkg::OP_TEST;
                  if (opcode_i[3:0] == `SSX_LO_RR || opcode_i[3:0] == `SSX_LO_RIR) begin
                     next_dst_addr = wreg(wbank_i, byte1_i[7:4]);
                     next_src_addr = wreg(wbank_i, byte1_i[3:0]);
                     next_src_ind = (opcode_i[3:0] == `SSX_LO_RIR);
                     next_len = `SSX_LEN_TWO;
                     next_cyc = (opcode_i[3:0] == `SSX_LO_RR) ? `SSX_CYC_SHORT : `SSX_CYC_LONG;
                  end else if (opcode_i[3:0] == `SSX_LO_GIM) begin
                     next_dst_addr = byte1_i;
                     next_src_val = byte2_i;
                     next_imm = 1'b1;
                     next_len = `SSX_LEN_THREE;
                     next_cyc = `SSX_CYC_LONG;
                  end else begin
                     // Source byte precedes destination in these forms
                     next_src_addr = byte1_i;
                     next_dst_addr = byte2_i;
                     next_src_ind = (opcode_i[3:0] == `SSX_LO_GIR);
                     next_len = `SSX_LEN_THREE;
                     next_cyc = `SSX_CYC_LONG;
                  end
               end
               if (next_op != ssx_pkg::OP_NONE) begin
                  next_rd_addr = next_dst_addr;
                  next_state = ssx_pkg::ST_PTR;
               end
            end
         end
         ssx_pkg::ST_PTR: begin
            // Resolve an indirect destination, then fetch it
            next_cyc = cyc - 3'h1;
            if (dst_ind) begin
               next_dst_addr = rd_data_i;
               next_dst_ind = 1'b0;
               next_rd_addr = rd_data_i;
            end else if (op == ssx_pkg::OP_STOP) begin
               next_state = ssx_pkg::ST_EXEC;
            end else begin
               next_dst_val = rd_data_i;
               if (op == ssx_pkg::OP_SHIFT || imm) begin
                  next_state = ssx_pkg::ST_EXEC;
               end else begin
                  next_rd_addr = src_addr;
                  next_state = ssx_pkg::ST_OPS;
               end
            end
         end
         ssx_pkg::ST_OPS: begin
            // Own state, so a source pointer equal to the destination is safe
            next_cyc = cyc - 3'h1;
            if (src_ind) begin
               next_src_addr = rd_data_i;
               next_src_ind = 1'b0;
               next_rd_addr = rd_data_i;
            end else begin
               next_src_val = rd_data_i;
               next_state = ssx_pkg::ST_EXEC;
            end
         end
         ssx_pkg::ST_EXEC: begin
            // Pad first, so results land exactly one cycle before retire
            next_cyc = cyc - 3'h1;
            if (cyc <= `SSX_CYC_LAST) begin
               next_state = ssx_pkg::ST_WAIT;
               case (op)
                  ssx_pkg::OP_SHIFT: begin
                     res = {dst_val[7], dst_val[7:1]};
                     next_wr = '{en: 1'b1, addr: dst_addr, data: res};
                     next_flg = '{c: dst_val[0], z: (res == 8'h00), s: res[7], v: 1'b0};
                     next_flg_we = 1'b1;
                  end
                  ssx_pkg::OP_SUB: begin
                     diff = {1'b0, dst_val} + {1'b0, ~src_val} + 9'h001;
                     res = diff[7:0];
                     next_wr = '{en: 1'b1, addr: dst_addr, data: res};
                     next_flg = '{c: ~diff[8], z: (res == 8'h00), s: res[7],
                                  v: (dst_val[7] ^ src_val[7]) & (res[7] == src_val[7])};
                     next_flg_we = 1'b1;
                  end
                  ssx_pkg::OP_INVTEST: begin
                     res = ~dst_val & src_val;
                     next_flg = '{c: flags_i.c, z: (res == 8'h00), s: res[7], v: 1'b0};
                     next_flg_we = 1'b1;
                  end
                  ssx_pkg::OP_TEST: begin
                     res = dst_val & src_val;
                     next_flg = '{c: flags_i.c, z: (res == 8'h00), s: res[7], v: 1'b0};
                     next_flg_we = 1'b1;
                  end
                  ssx_pkg::OP_STOP: begin
                     // Flags untouched either way
                     if (unlock_i == `SSX_UNLOCK_KEY) begin
                        next_halt = 1'b1;
                        next_state = ssx_pkg::ST_STOP;
                     end else begin
                        next_pc_rst = 1'b1;
                     end
                  end
                  default: begin
                     next_state = ssx_pkg::ST_WAIT;
                  end
               endcase
            end
         end
         ssx_pkg::ST_WAIT: begin
            // Pad to the documented cycle count
            if (cyc <= 3'h1) begin
               next_done = 1'b1;
               next_len_o = len;
               next_state = ssx_pkg::ST_IDLE;
            end else begin
               next_cyc = cyc - 3'h1;
            end
         end
         ssx_pkg::ST_STOP: begin
            // Only an external interrupt here; reset handles the rest
            if (ext_irq_i) begin
               next_halt = 1'b0;
               next_done = 1'b1;
               next_len_o = len;
               next_state = ssx_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = ssx_pkg::ST_IDLE;
         end
      endcase
      // Busy follows the state it will be in, so the output is a flop
      next_busy = (next_state != ssx_pkg::ST_IDLE);
   end

   // ----------------------------------------
   // State registers
   // ----------------------------------------
   // Registers only; nothing here changes while halted except wake
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= ssx_pkg::ST_IDLE;
         op <= ssx_pkg::OP_NONE;
         busy <= 1'b0;
         pc_val <= `SSX_RESET_PC;
         dst_addr <= 8'h00;
         src_addr <= 8'h00;
         dst_val <= 8'h00;
         src_val <= 8'h00;
         src_ind <= 1'b0;
         dst_ind <= 1'b0;
         imm <= 1'b0;
         cyc <= 3'h0;
         len <= 2'h0;
         rd_addr <= 8'h00;
         wr <= '0;
         flg <= '0;
         flg_we <= 1'b0;
         pc_rst <= 1'b0;
         halt <= 1'b0;
         done <= 1'b0;
         len_o <= 2'h0;
      end else begin
         state <= next_state;
         op <= next_op;
         busy <= next_busy;
         pc_val <= next_pc_val;
         dst_addr <= next_dst_addr;
         src_addr <= next_src_addr;
         dst_val <= next_dst_val;
         src_val <= next_src_val;
         src_ind <= next_src_ind;
         dst_ind <= next_dst_ind;
         imm <= next_imm;
         cyc <= next_cyc;
         len <= next_len;
         rd_addr <= next_rd_addr;
         wr <= next_wr;
         flg <= next_flg;
         flg_we <= next_flg_we;
         pc_rst <= next_pc_rst;
         halt <= next_halt;
         done <= next_done;
         len_o <= next_len_o;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign rd_addr_o = rd_addr;
   assign wr_o = wr;
   assign flags_o = flg;
   assign flags_we_o = flg_we;
   assign pc_reset_o = pc_rst;
   assign pc_value_o = pc_val;
   assign clk_halt_o = halt;
   assign done_o = done;
   assign length_o = len_o;
   assign busy_o = busy;
endmodule : ssx_exec

// File: dv/ssx_exec_assertions.sv
`timescale 1ns/10ps
module ssx_exec_checker (
   input wire logic clk_i, // Core clock
   input wire logic reset_n_i, // Async reset
   input wire logic start_i, // Start pulse
   input wire logic [7:0] opcode_i, // First byte
   input wire logic [7:0] unlock_i, // Unlock value
   input wire logic ext_irq_i, // Wake input
   input wire ssx_pkg::ssx_wr_t wr_o, // Write port
   input wire logic flags_we_o, // Flag load
   input wire logic pc_reset_o, // PC reload
   input wire logic [15:0] pc_value_o, // PC value
   input wire logic clk_halt_o, // Halted
   input wire logic done_o, // Retired
   input wire logic busy_o // In progress
);
   logic alu_op;
   // Opcodes that retire in a bounded time
   assign alu_op = (opcode_i[7:4] inside {4'h2, 4'h6, 4'h7} &&
                    opcode_i[3:0] inside {[4'h2:4'h6]}) || opcode_i inside {8'hd0, 8'hd1};
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   //----------------------------------------
   // Requests presented while idle
   //----------------------------------------
   sequence s_alu;
      start_i && !busy_o && alu_op;
   endsequence
   sequence s_junk;
      start_i && !busy_o && !alu_op && opcode_i != 8'h7f;
   endsequence
   sequence s_stop_ok;
      start_i && !busy_o && opcode_i == 8'h7f && unlock_i == 8'ha5 && !ext_irq_i;
   endsequence
   sequence s_stop_bad;
      start_i && !busy_o && opcode_i == 8'h7f && unlock_i != 8'ha5;
   endsequence
   //----------------------------------------
   // Properties
   //----------------------------------------
   a_alu_retire_bound: assert property (s_alu |-> ##[3:7] done_o)
      else $error("instruction did not retire in time");
   a_alu_goes_busy: assert property (s_alu |=> busy_o)
      else $error("accepted instruction not busy");
   a_junk_ignored: assert property (s_junk |=> !busy_o)
      else $error("unknown opcode accepted");
   a_write_then_done: assert property (wr_o.en |=> done_o)
      else $error("write not followed by retire");
   a_flags_then_done: assert property (flags_we_o |=> done_o)
      else $error("flag load not followed by retire");
   a_stop_halts: assert property (s_stop_ok |-> ##[1:5] clk_halt_o)
      else $error("unlocked stop did not halt");
   a_stop_key_jump: assert property (s_stop_bad |-> ##[1:5] pc_reset_o)
      else $error("locked stop did not reload PC");
   a_stop_no_flags: assert property (s_stop_bad |=> !flags_we_o [*4])
      else $error("stop touched flags");
   a_halt_holds: assert property (clk_halt_o && !ext_irq_i |=> clk_halt_o)
      else $error("halt left without wake");
   a_halt_wakes: assert property (clk_halt_o && ext_irq_i |-> ##[1:4] !clk_halt_o)
      else $error("wake did not release halt");
   a_halt_quiet: assert property (clk_halt_o |-> !wr_o.en && !flags_we_o)
      else $error("state changed while halted");
   a_pc_reset_val: assert property (pc_reset_o |-> pc_value_o == 16'h0100 && !clk_halt_o)
      else $error("bad PC reload");
endmodule : ssx_exec_checker

bind ssx_exec ssx_exec_checker ssx_exec_checker_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
   .start_i(start_i), .opcode_i(opcode_i), .unlock_i(unlock_i), .ext_irq_i(ext_irq_i),
   .wr_o(wr_o), .flags_we_o(flags_we_o), .pc_reset_o(pc_reset_o), .pc_value_o(pc_value_o),
   .clk_halt_o(clk_halt_o), .done_o(done_o), .busy_o(busy_o));

// File: dv/ssx_tb.sv
`timescale 1ns/10ps
module testbench;
   logic clk_i = 0;
   logic reset_n_i = 0;
   logic start_i = 0;
   logic ext_irq_i = 0;
   logic [7:0] opcode_i = 0, byte1_i = 0, byte2_i = 0, unlock_i = 0, rd_addr_o;
   logic [3:0] wbank_i = 0;
   ssx_pkg::ssx_flags_t fl = 0, flags_o;
   ssx_pkg::ssx_wr_t wr_o;
   logic flags_we_o, pc_reset_o, clk_halt_o, done_o, busy_o;
   logic [15:0] pc_value_o;
   logic [1:0] length_o;
   logic [7:0] mem [256];
   int errors = 0, samples_checked = 0, wcnt = 0, pcnt = 0;
   ssx_exec ssx_exec_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start_i),
      .opcode_i(opcode_i), .byte1_i(byte1_i), .byte2_i(byte2_i), .wbank_i(wbank_i),
      .unlock_i(unlock_i), .ext_irq_i(ext_irq_i), .flags_i(fl), .rd_addr_o(rd_addr_o),
      .rd_data_i(mem[rd_addr_o]), .wr_o(wr_o), .flags_o(flags_o), .flags_we_o(flags_we_o),
      .pc_reset_o(pc_reset_o), .pc_value_o(pc_value_o), .clk_halt_o(clk_halt_o),
      .done_o(done_o), .length_o(length_o), .busy_o(busy_o));
   // 8 ns clock
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   // Register file, flag register and PC reload seen by the core
   always @(posedge clk_i) begin
      if (wr_o.en === 1'b1) begin
         mem[wr_o.addr] <= wr_o.data;
         wcnt <= wcnt + 1;
      end
      if (flags_we_o === 1'b1) fl <= flags_o;
      if (pc_reset_o === 1'b1) pcnt <= pcnt + 1;
   end
   //----------------------------------------
   // Helpers
   //----------------------------------------
   task chk(input logic [15:0] got, exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task run(input logic [7:0] op, b1, b2, input int cyc, input logic [1:0] len);
      int n;
      @(negedge clk_i);
      opcode_i = op;
      byte1_i = b1;
      byte2_i = b2;
      start_i = 1'b1;
      @(negedge clk_i);
      start_i = 1'b0;
      n = 1;
      // Bounded wait: a stuck core shows up as a count error
      while (done_o !== 1'b1 && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      chk(16'(n - 1), 16'(cyc), "cycle count");
      chk(16'(length_o), 16'(len), "length");
   endtask : run
   task alu(input logic [7:0] op, b1, b2, input int cyc, input logic [1:0] len,
            input logic [7:0] dst, expd, input logic [3:0] expf);
      run(op, b1, b2, cyc, len);
      chk(16'(mem[dst]), 16'(expd), "result");
      chk(16'(fl), 16'(expf), "flags");
   endtask : alu
   //----------------------------------------
   // Scenarios
   //----------------------------------------
   task t_shift();
      fl = 4'hd;
      mem[8'h00] = 8'h9a;
      mem[8'h02] = 8'h03;
      mem[8'h03] = 8'hbc;
      mem[8'h05] = 8'h01;
      alu(8'hd0, 8'h00, 8'h00, 4, 2'h2, 8'h00, 8'hcd, 4'h2);
      alu(8'hd1, 8'h02, 8'h00, 4, 2'h2, 8'h03, 8'hde, 4'h2);
      alu(8'hd0, 8'h05, 8'h00, 4, 2'h2, 8'h05, 8'h00, 4'hc);
   endtask : t_shift
   task t_sub();
      mem[8'hc1] = 8'h12;
      mem[8'hc2] = 8'h03;
      mem[8'h03] = 8'h0a;
      alu(8'h22, 8'h12, 8'h00, 4, 2'h2, 8'hc1, 8'h0f, 4'h0);
      chk(16'(mem[8'hc2]), 16'h03, "source kept");
      mem[8'hc1] = 8'h12;
      alu(8'h23, 8'h12, 8'h00, 6, 2'h2, 8'hc1, 8'h08, 4'h0);
      mem[8'h01] = 8'h21;
      alu(8'h24, 8'h02, 8'h01, 6, 2'h3, 8'h01, 8'h1e, 4'h0);
      mem[8'h01] = 8'h21;
      alu(8'h25, 8'h02, 8'h01, 6, 2'h3, 8'h01, 8'h17, 4'h0);
      mem[8'h01] = 8'h21;
      alu(8'h26, 8'h01, 8'h90, 6, 2'h3, 8'h01, 8'h91, 4'hb);
      mem[8'h01] = 8'h21;
      alu(8'h26, 8'h01, 8'h65, 6, 2'h3, 8'h01, 8'hbc, 4'ha);
      alu(8'h26, 8'h01, 8'hbc, 6, 2'h3, 8'h01, 8'h00, 4'h4);
      wbank_i = 4'h1;
      mem[8'hd1] = 8'h12;
      mem[8'hd2] = 8'h03;
      alu(8'h22, 8'h12, 8'h00, 4, 2'h2, 8'hd1, 8'h0f, 4'h0);
      wbank_i = 4'h0;
   endtask : t_sub
   task t_mask();
      int w;
      mem[8'hc0] = 8'hc7;
      mem[8'hc1] = 8'h02;
      mem[8'h02] = 8'h23;
      mem[8'h00] = 8'h2b;
      mem[8'h01] = 8'h02;
      fl = 4'h9;
      w = wcnt;
      alu(8'h62, 8'h01, 8'h00, 4, 2'h2, 8'hc0, 8'hc7, 4'hc);
      alu(8'h63, 8'h01, 8'h00, 6, 2'h2, 8'hc0, 8'hc7, 4'h8);
      alu(8'h64, 8'h01, 8'h00, 6, 2'h3, 8'h00, 8'h2b, 4'hc);
      alu(8'h65, 8'h01, 8'h00, 6, 2'h3, 8'h00, 8'h2b, 4'hc);
      alu(8'h66, 8'h00, 8'h80, 6, 2'h3, 8'h00, 8'h2b, 4'ha);
      fl = 4'h1;
      alu(8'h72, 8'h01, 8'h00, 4, 2'h2, 8'hc0, 8'hc7, 4'h0);
      alu(8'h73, 8'h01, 8'h00, 6, 2'h2, 8'hc0, 8'hc7, 4'h0);
      alu(8'h74, 8'h01, 8'h00, 6, 2'h3, 8'h00, 8'h2b, 4'h0);
      alu(8'h75, 8'h01, 8'h00, 6, 2'h3, 8'h00, 8'h2b, 4'h0);
      alu(8'h76, 8'h00, 8'h54, 6, 2'h3, 8'h00, 8'h2b, 4'h4);
      alu(8'h76, 8'hc0, 8'h80, 6, 2'h3, 8'hc0, 8'hc7, 4'h2);
      chk(16'(wcnt - w), 16'h0, "mask test wrote");
   endtask : t_mask
   task t_stop();
      int n, w;
      w = wcnt;
      fl = 4'h5;
      unlock_i = 8'ha5;
      @(negedge clk_i);
      opcode_i = 8'h7f;
      start_i = 1'b1;
      @(negedge clk_i);
      start_i = 1'b0;
      repeat (30) @(negedge clk_i);
      chk(16'(clk_halt_o), 16'h1, "halted");
      ext_irq_i = 1'b1;
      n = 0;
      while (done_o !== 1'b1 && n < 10) begin
         @(negedge clk_i);
         n++;
      end
      ext_irq_i = 1'b0;
      @(negedge clk_i);
      chk(16'(clk_halt_o), 16'h0, "woken");
      chk({12'h0, fl}, 16'h5, "stop flags");
      chk(16'(wcnt - w), 16'h0, "stop wrote");
      unlock_i = 8'h00;
      n = pcnt;
      run(8'h7f, 8'h00, 8'h00, 4, 2'h1);
      chk(16'(pcnt - n), 16'h1, "PC reload");
      chk(16'(clk_halt_o), 16'h0, "locked stop halted");
      chk(pc_value_o, 16'h0100, "PC value");
      // Stop again; it retires only on an interrupt wake, so it is issued by hand
      unlock_i = 8'ha5;
      @(negedge clk_i);
      start_i = 1'b1;
      @(negedge clk_i);
      start_i = 1'b0;
      repeat (4) @(negedge clk_i);
      chk(16'(clk_halt_o), 16'h1, "halted again");
      // Wake by reset, held low several cycles
      reset_n_i = 1'b0;
      repeat (5) @(negedge clk_i);
      reset_n_i = 1'b1;
      chk(16'(clk_halt_o), 16'h0, "reset wake");
      @(negedge clk_i);
      opcode_i = 8'h00;
      start_i = 1'b1;
      @(negedge clk_i);
      start_i = 1'b0;
      chk(16'(busy_o), 16'h0, "unknown opcode");
   endtask : t_stop
   //----------------------------------------
   // Sequencing and verdict
   //----------------------------------------
   task finish_test();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   // Watchdog: the whole run needs well under 5000 cycles
   initial begin
      #40000;
      errors++;
      finish_test();
   end
   // Main sequence
   initial begin
      repeat (10) @(negedge clk_i);
      reset_n_i = 1'b1;
      t_shift();
      t_sub();
      t_mask();
      t_stop();
      finish_test();
   end
endmodule : testbench
